// ===== logic/flash_guard_pkg.sv
// Constants and types shared by the flash write guard
package flash_guard_pkg;
	localparam logic [7:0]  OFF_STORE_CTRL   = 8'h8F;
	localparam logic [7:0]  OFF_READ_TIMING  = 8'hB6;
	localparam logic [7:0]  OFF_UNLOCK_KEY   = 8'hB7;
	localparam logic [7:0]  RST_STORE_CTRL   = 8'h00;
	localparam logic [7:0]  RST_READ_TIMING  = 8'h80;
	localparam int          BIT_WRITE_EN     = 0;
	localparam int          BIT_ERASE_EN     = 1;
	localparam int          BIT_ONESHOT      = 7;
	localparam int          BIT_READ_TIME    = 4;
	localparam logic [7:0]  KEY_FIRST        = 8'hA5;
	localparam logic [7:0]  KEY_SECOND       = 8'hF1;
	localparam logic [15:0] RESERVED_BASE    = 16'hFC00;
	localparam logic [15:0] LOCKPAGE_64K     = 16'hFA00;
	localparam logic [15:0] LOCKPAGE_32K     = 16'h7E00;
	localparam int          PAGE_SHIFT       = 9;
	localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
	// Operation times in microseconds, scaled to 200 MHz cycles
	localparam int          CLK_MHZ          = 200;
	localparam int          WRITE_TIME_US    = 40;
	localparam int          ERASE_TIME_US    = 10000;
	localparam int          WRITE_CYCLES     = WRITE_TIME_US * CLK_MHZ;
	localparam int          ERASE_CYCLES     = ERASE_TIME_US * CLK_MHZ;
	typedef enum logic [1:0] {
		KEY_LOCKED   = 2'h0,
		KEY_HALF     = 2'h1,
		KEY_OPEN     = 2'h2,
		KEY_DISABLED = 2'h3
	} key_state_e;
	typedef enum logic [1:0] {
		SRC_DEBUG, SRC_FW_UNLOCKED, SRC_FW_LOCKED
	} src_e;
endpackage : flash_guard_pkg

// ===== logic/flash_write_guard.sv
// Flash access guard: key sequence, page locks, read timing controls
// Notes on behaviour
// - Modify needs write enable; erase also erase enable
// - Write enable steers data writes into flash
// - Both enables make writes erase whole page
// - Lock count is inverse of lock byte
// - Any lock also locks lock-byte page
// - Debug port blocked on locked pages
// - Lock byte itself always readable
// - Clearing lock byte bits is refused
// - Only debug device erase unlocks pages
// - Firmware never erases lock-byte page
// - Unlocked code barred from locked pages
// - Locked code may use locked pages
// - Reserved denied; firmware violations cause reset
// - Reserved area is 0xFC00 to 0xFFFF
// - Keys 0xA5 then 0xF1, any delay
// - Lock returns after every write or erase
// - Bad key or early op disables until reset
// - Key register reads back lock state
// - One-shot bit selects sense-amp pulse, resets one
// - Writes only clear bits; erase sets FF
// - Core stalls while operation is timed
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module flash_write_guard
	import flash_guard_pkg::*;
#(
	parameter int WRITE_CNT = flash_guard_pkg::WRITE_CYCLES,
	parameter int ERASE_CNT = flash_guard_pkg::ERASE_CYCLES,
	parameter bit SIZE_64K  = 1'b1
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        clkEn,
	// Wishbone register slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output var  logic [31:0] wb_dat_o,
	output var  logic        wb_ack_o,
	// Core data-move and code-read requests
	input  wire logic        moveWrReq,
	input  wire logic [15:0] moveAddr,
	input  wire logic [7:0]  moveData,
	input  wire logic        codeRdReq,
	input  wire logic [15:0] codeRdAddr,
	input  wire logic [15:0] execPc,
	output var  logic        ramWrStb,
	output var  logic        coreStall,
	output var  logic        rdValid,
	output var  logic [7:0]  rdData,
	output var  logic        senseFull,
	output var  logic        senseOneShot,
	output var  logic        flashErrReset,
	// Two-wire debug port requests
	input  wire logic        dbgReq,
	input  wire logic [1:0]  dbgOp,
	input  wire logic [15:0] dbgAddr,
	input  wire logic [7:0]  dbgData,
	output var  logic        dbgDone,
	output var  logic        dbgDenied,
	output var  logic [7:0]  dbgRdData,
	// Stored lock byte loaded from the array
	input  wire logic [7:0]  lockByteIn
);
	import flash_guard_pkg::*;

	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_WRITE = 2'h1;
	localparam logic [1:0] OP_ERASE = 2'h2;
	localparam logic [1:0] OP_CHIP = 2'h3;
	localparam int MEM_BYTES = SIZE_64K ? 65536 : 32768;
	localparam logic [15:0] LOCK_PAGE = SIZE_64K ? LOCKPAGE_64K : LOCKPAGE_32K;
	localparam logic [15:0] LOCK_ADDR = LOCK_PAGE | 16'h01FF;

	logic [7:0]  flashMem [MEM_BYTES];
	logic [7:0]  storeCtrl_r;
	logic [7:0]  readTiming_r;
	key_state_e  keyState_r;
	logic [7:0]  lockByte_r;
	logic [31:0] busyCnt_r;
	logic        busy_r;
	logic        rdPend_r;
	logic        ackPend_r;

	// Page helpers
	function automatic logic [6:0] pageOf(input logic [15:0] a);
		pageOf = a[15:PAGE_SHIFT];
	endfunction : pageOf

	function automatic logic pageLocked(input logic [15:0] a,
			input logic [7:0] lb);
		logic [7:0] n;
		n = ~lb;
		pageLocked = ({1'b0, pageOf(a)} < n) ||
			((n != 8'h00) && pageOf(a) == pageOf(LOCK_PAGE));
	endfunction : pageLocked

	// Decide access for a source, address and operation
	function automatic logic allowed(input src_e s, input logic [15:0] a,
			input logic [1:0] op, input logic [7:0] lb, input logic [7:0] d);
		logic lk;
		logic lp;
		lk = pageLocked(a, lb);
		lp = pageOf(a) == pageOf(LOCK_PAGE);
		allowed = 1'b0;
		if (a >= RESERVED_BASE || {16'h0, a} >= MEM_BYTES) begin
			allowed = 1'b0;
		end else if (op == OP_READ && a == LOCK_ADDR) begin
			allowed = 1'b1;
		end else if (op == OP_WRITE && a == LOCK_ADDR && (~d & lb) != 8'h00) begin
			allowed = 1'b0;
		end else begin
			unique case (s)
				SRC_DEBUG:       allowed = !lk;
				SRC_FW_UNLOCKED: allowed = !lk && !(lp && op == OP_ERASE);
				SRC_FW_LOCKED:   allowed = !(lp && op == OP_ERASE);
			endcase
		end
	endfunction : allowed

	logic bSel;
	logic bWr;
	assign bSel = wb_cyc_i && wb_stb_i && !ackPend_r && !wb_ack_o;
	assign bWr = bSel && wb_we_i && wb_sel_i[0];

	src_e fwSrc;
	assign fwSrc = pageLocked(execPc, lockByte_r) ? SRC_FW_LOCKED
		: SRC_FW_UNLOCKED;

	logic fwWrEn;
	logic fwErase;
	logic [1:0] fwOp;
	assign fwWrEn = storeCtrl_r[BIT_WRITE_EN];
	assign fwErase = fwWrEn && storeCtrl_r[BIT_ERASE_EN];
	assign fwOp = fwErase ? OP_ERASE : OP_WRITE;

	logic fwGo;
	logic fwTry;
	assign fwTry = clkEn && moveWrReq && fwWrEn && !busy_r;
	assign fwGo = fwTry && keyState_r == KEY_OPEN
		&& allowed(fwSrc, moveAddr, fwOp, lockByte_r, moveData);

	logic dbgGo;
	assign dbgGo = clkEn && dbgReq && !busy_r && (dbgOp == OP_CHIP
		|| allowed(SRC_DEBUG, dbgAddr, dbgOp, lockByte_r, dbgData));

	// Register writes; unused bits drop on write
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			storeCtrl_r  <= RST_STORE_CTRL;
			readTiming_r <= RST_READ_TIMING;
		end else if (clkEn && bWr) begin
			if (wb_adr_i == OFF_STORE_CTRL)
				storeCtrl_r <= wb_dat_i[7:0] & 8'h03;
			if (wb_adr_i == OFF_READ_TIMING)
				readTiming_r <= wb_dat_i[7:0] & 8'h90;
		end
	end

	// Key state machine
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			keyState_r <= KEY_LOCKED;
		end else if (clkEn) begin
			if (fwTry && keyState_r != KEY_OPEN) begin
				keyState_r <= KEY_DISABLED;
			end else if (fwTry) begin
				keyState_r <= KEY_LOCKED;
			end else if (bWr && wb_adr_i == OFF_UNLOCK_KEY) begin
				unique case (keyState_r)
					KEY_LOCKED: keyState_r <= (wb_dat_i[7:0] == KEY_FIRST)
						? KEY_HALF : KEY_DISABLED;
					KEY_HALF: keyState_r <= (wb_dat_i[7:0] == KEY_SECOND)
						? KEY_OPEN : KEY_DISABLED;
					KEY_OPEN: keyState_r <= KEY_DISABLED;
					KEY_DISABLED: keyState_r <= KEY_DISABLED;
				endcase
			end
		end
	end

	// Flash error reset pulse for illegal firmware access
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			flashErrReset <= 1'b0;
		else if (clkEn)
			flashErrReset <= (fwTry && keyState_r == KEY_OPEN && !fwGo)
				|| (codeRdReq && !busy_r
				&& !allowed(fwSrc, codeRdAddr, OP_READ, lockByte_r, 8'h00));
	end

	// Data writes go to RAM when flash writes are off
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			ramWrStb <= 1'b0;
		else if (clkEn)
			ramWrStb <= moveWrReq && !fwWrEn;
	end

	// Program array; timing busy stalls the core
	always_ff @(posedge ref_clk) begin
		if (clkEn && fwGo && fwErase) begin
			for (int i = 0; i < 512; i++)
				flashMem[{moveAddr[15:9], 9'(i)}] <= ERASED_BYTE;
		end else if (clkEn && fwGo) begin
			flashMem[moveAddr] <= flashMem[moveAddr] & moveData;
		end else if (dbgGo && dbgOp == OP_WRITE) begin
			flashMem[dbgAddr] <= flashMem[dbgAddr] & dbgData;
		end else if (dbgGo && dbgOp == OP_ERASE) begin
			for (int i = 0; i < 512; i++)
				flashMem[{dbgAddr[15:9], 9'(i)}] <= ERASED_BYTE;
		end else if (dbgGo && dbgOp == OP_CHIP) begin
			// Whole array goes, lock-byte page and lock byte too
			for (int i = 0; i < MEM_BYTES; i++)
				flashMem[i] <= ERASED_BYTE;
		end
	end

	// Lock byte copy; only reset or a device erase raises its bits
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			lockByte_r <= ERASED_BYTE;
		else if (clkEn && dbgGo && dbgOp == OP_CHIP)
			lockByte_r <= ERASED_BYTE;
		else if (clkEn && !busy_r && !dbgReq && !moveWrReq)
			lockByte_r <= lockByte_r & lockByteIn;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			busy_r    <= 1'b0;
			busyCnt_r <= 32'h0;
			coreStall <= 1'b0;
		end else if (clkEn) begin
			if (fwGo || (dbgGo && dbgOp != OP_READ)) begin
				busy_r    <= 1'b1;
				coreStall <= 1'b1;
				busyCnt_r <= ((fwGo && fwErase) || (!fwGo && dbgOp != OP_WRITE))
					? 32'(ERASE_CNT) : 32'(WRITE_CNT);
			end else if (busyCnt_r > 32'h1) begin
				busyCnt_r <= busyCnt_r - 32'h1;
			end else begin
				busy_r    <= 1'b0;
				coreStall <= 1'b0;
				busyCnt_r <= 32'h0;
			end
		end
	end

	// Code reads with optional wait cycle and sense-amp control
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdPend_r     <= 1'b0;
			rdValid      <= 1'b0;
			rdData       <= 8'h00;
			senseFull    <= 1'b0;
			senseOneShot <= 1'b0;
		end else if (clkEn) begin
			rdValid      <= 1'b0;
			senseFull    <= 1'b0;
			senseOneShot <= 1'b0;
			if (codeRdReq && !busy_r && !rdPend_r
					&& allowed(fwSrc, codeRdAddr, OP_READ, lockByte_r, 8'h00)) begin
				senseOneShot <= readTiming_r[BIT_ONESHOT];
				senseFull    <= !readTiming_r[BIT_ONESHOT];
				if (readTiming_r[BIT_READ_TIME]) begin
					rdPend_r <= 1'b1;
				end else begin
					rdValid <= 1'b1;
					rdData  <= flashMem[codeRdAddr];
				end
			end else if (rdPend_r) begin
				rdPend_r <= 1'b0;
				rdValid  <= 1'b1;
				rdData   <= flashMem[codeRdAddr];
			end
		end
	end

	// Debug answers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			dbgDone   <= 1'b0;
			dbgDenied <= 1'b0;
			dbgRdData <= 8'h00;
		end else if (clkEn) begin
			dbgDone   <= dbgReq && !busy_r && dbgGo;
			dbgDenied <= dbgReq && !busy_r && !dbgGo;
			if (dbgGo && dbgOp == OP_READ)
				dbgRdData <= flashMem[dbgAddr];
		end
	end

	// Wishbone: ack one cycle after strobe, reads zero-extended
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wb_ack_o  <= 1'b0;
			wb_dat_o  <= 32'h0;
			ackPend_r <= 1'b0;
		end else if (clkEn) begin
			wb_ack_o  <= bSel;
			ackPend_r <= bSel;
			if (bSel && !wb_we_i) begin
				unique case (wb_adr_i)
					OFF_STORE_CTRL:  wb_dat_o <= {24'h0, storeCtrl_r};
					OFF_READ_TIMING: wb_dat_o <= {24'h0, readTiming_r};
					OFF_UNLOCK_KEY:  wb_dat_o <= {30'h0, keyState_r};
					default:         wb_dat_o <= 32'h0;
				endcase
			end
		end
	end

	property p_key_open;
		@(posedge ref_clk) disable iff (!resetn)
		(clkEn && keyState_r == KEY_HALF && bWr && wb_adr_i == OFF_UNLOCK_KEY
			&& wb_dat_i[7:0] == KEY_SECOND && !fwTry) |=> keyState_r == KEY_OPEN;
	endproperty
	a_key_open: assert property (p_key_open) else $error("key open");

	property p_relock;
		@(posedge ref_clk) disable iff (!resetn)
		(fwGo) |=> keyState_r == KEY_LOCKED && busy_r;
	endproperty
	a_relock: assert property (p_relock) else $error("relock");

	property p_disable_sticky;
		@(posedge ref_clk) disable iff (!resetn)
		keyState_r == KEY_DISABLED |=> keyState_r == KEY_DISABLED;
	endproperty
	a_disable_sticky: assert property (p_disable_sticky) else $error("sticky");

	property p_ram_steer;
		@(posedge ref_clk) disable iff (!resetn)
		(clkEn && moveWrReq) |=> ramWrStb == !$past(fwWrEn);
	endproperty
	a_ram_steer: assert property (p_ram_steer) else $error("steer");

	property p_no_early;
		@(posedge ref_clk) disable iff (!resetn)
		(clkEn && moveWrReq && !busy_r && !dbgReq
			&& (keyState_r != KEY_OPEN || !fwWrEn)) |=> !busy_r;
	endproperty
	a_no_early: assert property (p_no_early) else $error("early");

	property p_reserved;
		@(posedge ref_clk) disable iff (!resetn)
		(dbgGo && dbgOp != OP_CHIP) |-> dbgAddr < RESERVED_BASE;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved");

	property p_ctrl_zero;
		@(posedge ref_clk) disable iff (!resetn)
		##1 storeCtrl_r[7:2] == 6'h0;
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero) else $error("unused");

	property p_wait_read;
		@(posedge ref_clk) disable iff (!resetn)
		(clkEn && senseFull | senseOneShot && readTiming_r[BIT_READ_TIME])
			|-> !rdValid;
	endproperty
	a_wait_read: assert property (p_wait_read) else $error("wait");

	property p_unlock;
		@(posedge ref_clk) disable iff (!resetn)
		(dbgGo && dbgOp == OP_CHIP) |=> lockByte_r == ERASED_BYTE;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock");
endmodule : flash_write_guard
`default_nettype wire

// ===== test/dbg_port_model.sv
// Debug programmer model on the two-wire debug request port
`timescale 1ns/100ps
`default_nettype none
module dbg_port_model #(
	parameter logic [7:0] LOCK_VAL = 8'hFD
) (
	// Clock
	input  wire logic        ref_clk,
	// Debug requests
	output var  logic        dbgReq,
	output var  logic [1:0]  dbgOp,
	output var  logic [15:0] dbgAddr,
	output var  logic [7:0]  dbgData,
	input  wire logic        dbgDone,
	input  wire logic        dbgDenied,
	input  wire logic [7:0]  dbgRdData,
	// Stored lock byte
	output var  logic [7:0]  lockByteIn
);
	initial begin
		dbgReq = 1'b0;
		dbgOp = 2'h0;
		dbgAddr = 16'h0000;
		dbgData = 8'h00;
		lockByteIn = LOCK_VAL;
	end

	// Holds the request until an answer is sampled, then scrambles lines
	task automatic access(input logic [1:0] op, input logic [15:0] a,
		input logic [7:0] d, output logic den, output logic [7:0] rd);
		dbgReq <= 1'b1;
		dbgOp <= op;
		dbgAddr <= a;
		dbgData <= d;
		do begin
			@(posedge ref_clk);
		end while (dbgDone !== 1'b1 && dbgDenied !== 1'b1);
		den = dbgDenied;
		rd = dbgRdData;
		// A finished device erase leaves the stored lock byte blank
		if (op == 2'h3 && dbgDone === 1'b1)
			lockByteIn <= 8'hFF;
		dbgReq <= 1'b0;
		dbgAddr <= ~a;
		dbgData <= 8'h00;
		@(posedge ref_clk);
	endtask : access
endmodule : dbg_port_model
`default_nettype wire

// ===== test/flash_write_guard_and_page_lock_tb.sv
// Self-checking bench for the flash write guard
`timescale 1ns/100ps
`default_nettype none
module flash_write_guard_and_page_lock_tb;
	import flash_guard_pkg::*;
	localparam int WCNT = 4;
	localparam int ECNT = 8;
	localparam logic [7:0] LOCK = 8'hFD;
	logic ref_clk = 1'b0, resetn = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic moveWrReq = 1'b0, codeRdReq = 1'b0;
	logic [15:0] moveAddr = 16'h0, codeRdAddr = 16'h0, execPc = 16'h2000;
	logic [7:0] moveData = 8'h0, rdData, dbgData, dbgRdData, lockByteIn, q;
	logic ramWrStb, coreStall, rdValid, senseFull, senseOneShot;
	logic flashErrReset, dbgReq, dbgDone, dbgDenied, ram, e, sf, so, den;
	logic [1:0] dbgOp;
	logic [15:0] dbgAddr, a;
	int mismatches = 0, comparisons = 0, st, lat;
	int seed = 32'h4DD63153;

	always #2.5 ref_clk = ~ref_clk;

	flash_write_guard #(.WRITE_CNT(WCNT), .ERASE_CNT(ECNT))
		flash_write_guard_inst (.ref_clk(ref_clk), .resetn(resetn),
		.clkEn(1'b1), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.moveWrReq(moveWrReq), .moveAddr(moveAddr), .moveData(moveData),
		.codeRdReq(codeRdReq), .codeRdAddr(codeRdAddr), .execPc(execPc),
		.ramWrStb(ramWrStb), .coreStall(coreStall), .rdValid(rdValid),
		.rdData(rdData), .senseFull(senseFull), .senseOneShot(senseOneShot),
		.flashErrReset(flashErrReset), .dbgReq(dbgReq), .dbgOp(dbgOp),
		.dbgAddr(dbgAddr), .dbgData(dbgData), .dbgDone(dbgDone),
		.dbgDenied(dbgDenied), .dbgRdData(dbgRdData),
		.lockByteIn(lockByteIn));

	dbg_port_model #(.LOCK_VAL(LOCK)) dbg_port_model_inst (
		.ref_clk(ref_clk), .dbgReq(dbgReq), .dbgOp(dbgOp),
		.dbgAddr(dbgAddr), .dbgData(dbgData), .dbgDone(dbgDone),
		.dbgDenied(dbgDenied), .dbgRdData(dbgRdData),
		.lockByteIn(lockByteIn));

	task automatic chk(input string nm, input logic [31:0] ex, g);
		comparisons++;
		if (g !== ex) begin
			mismatches++;
			$display("ERROR %s expected %0h seen %0h", nm, ex, g);
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] ad, d,
		output logic [7:0] r);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= ad;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge ref_clk);
		end while (wb_ack_o !== 1'b1);
		r = wb_dat_o[7:0];
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask : wb

	task automatic keys();
		wb(1'b1, OFF_UNLOCK_KEY, KEY_FIRST, q);
		wb(1'b1, OFF_UNLOCK_KEY, KEY_SECOND, q);
	endtask : keys

	// Watch long enough for the longest operation to finish
	task automatic mv(input logic [15:0] ad);
		moveWrReq <= 1'b1;
		moveAddr <= ad;
		moveData <= 8'($random(seed));
		@(posedge ref_clk);
		moveWrReq <= 1'b0;
		st = 0;
		ram = 0;
		e = 0;
		repeat (ECNT + 4) begin
			@(posedge ref_clk);
			st += int'(coreStall === 1'b1);
			ram |= (ramWrStb === 1'b1);
			e |= (flashErrReset === 1'b1);
		end
	endtask : mv

	task automatic crd(input logic [15:0] pc, ad);
		codeRdReq <= 1'b1;
		codeRdAddr <= ad;
		execPc <= pc;
		lat = 0;
		e = 0;
		sf = 0;
		so = 0;
		@(posedge ref_clk);
		codeRdReq <= 1'b0;
		do begin
			@(posedge ref_clk);
			lat++;
			e |= (flashErrReset === 1'b1);
			sf |= (senseFull === 1'b1);
			so |= (senseOneShot === 1'b1);
		end while (rdValid !== 1'b1 && !e && lat < 8);
		repeat (2) @(posedge ref_clk);
	endtask : crd

	function automatic logic dbg_ok(input logic [15:0] ad);
		logic [7:0] n;
		logic       lk;
		n = ~LOCK;
		lk = (n != 8'h00) && (({1'b0, ad[15:9]} < n)
			|| ad[15:9] == LOCKPAGE_64K[15:9]);
		if (ad >= RESERVED_BASE)
			return 1'b0;
		if (ad == LOCKPAGE_64K + 16'h01FF)
			return 1'b1;
		return !lk;
	endfunction : dbg_ok

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	initial begin
		#(5 * 30000);
		mismatches++;
		end_sim();
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		wb(1'b0, OFF_STORE_CTRL, 8'h00, q);
		chk("ctrl reset", RST_STORE_CTRL, q);
		wb(1'b0, OFF_READ_TIMING, 8'h00, q);
		chk("timing reset", RST_READ_TIMING, q);
		wb(1'b0, OFF_UNLOCK_KEY, 8'h00, q);
		chk("key reset", 8'h00, q);
		wb(1'b0, 8'h10, 8'h00, q);
		chk("unmapped", 8'h00, q);
		wb(1'b1, OFF_STORE_CTRL, 8'hFC, q);
		wb(1'b0, OFF_STORE_CTRL, 8'h00, q);
		chk("ctrl unused", 8'h00, q);
		mv(16'h1000);
		chk("ram write", 1'b1, ram);
		chk("ram nostall", 0, st);
		wb(1'b1, OFF_UNLOCK_KEY, KEY_FIRST, q);
		wb(1'b0, OFF_UNLOCK_KEY, 8'h00, q);
		chk("key half", 8'h01, q);
		wb(1'b1, OFF_UNLOCK_KEY, KEY_SECOND, q);
		wb(1'b0, OFF_UNLOCK_KEY, 8'h00, q);
		chk("key open", 8'h02, q);
		wb(1'b1, OFF_STORE_CTRL, 8'h01, q);
		mv(16'h1000);
		chk("write stall", WCNT, st);
		wb(1'b0, OFF_UNLOCK_KEY, 8'h00, q);
		chk("relock", 8'h00, q);
		keys();
		wb(1'b1, OFF_STORE_CTRL, 8'h03, q);
		mv(16'h1234);
		chk("erase stall", ECNT, st);
		keys();
		wb(1'b1, OFF_STORE_CTRL, 8'h01, q);
		mv(16'h0000);
		chk("fw locked write", 1'b1, e);
		crd(16'h0000, 16'h0200);
		chk("locked code read", 1, lat);
		chk("one shot", 1'b1, so);
		wb(1'b1, OFF_READ_TIMING, 8'h90, q);
		crd(16'h0000, 16'h0200);
		chk("slow read", 2, lat);
		wb(1'b1, OFF_READ_TIMING, 8'h00, q);
		crd(16'h2000, 16'h1234);
		chk("full sense", 1'b1, sf);
		chk("no one shot", 1'b0, so);
		chk("code read data", ERASED_BYTE, rdData);
		crd(16'h2000, 16'h0000);
		chk("fw locked read", 1'b1, e);
		crd(16'h0000, RESERVED_BASE);
		chk("fw reserved", 1'b1, e);
		for (int i = 0; i < 13; i++) begin
			case (i)
				0: a = 16'h0000;
				1: a = 16'h0400;
				2: a = LOCKPAGE_64K;
				3: a = 16'hFBFF;
				4: a = RESERVED_BASE;
				default: a = 16'($random(seed));
			endcase
			dbg_port_model_inst.access(2'h0, a, 8'hFF, den, q);
			chk("dbg read", !dbg_ok(a), den);
		end
		dbg_port_model_inst.access(2'h2, 16'h0000, 8'hFF, den, q);
		chk("dbg erase", 1'b1, den);
		dbg_port_model_inst.access(2'h3, 16'h0000, 8'hFF, den, q);
		chk("dbg device erase", 1'b0, den);
		dbg_port_model_inst.access(2'h0, 16'h0000, 8'hFF, den, q);
		chk("dbg unlocked", 1'b0, den);
		chk("dbg erased", ERASED_BYTE, q);
		dbg_port_model_inst.access(2'h1, 16'hFBFF, 8'hFE, den, q);
		chk("lock byte clear", 1'b1, den);
		mv(16'h1000);
		keys();
		wb(1'b0, OFF_UNLOCK_KEY, 8'h00, q);
		chk("disabled", 8'h03, q);
		end_sim();
	end
endmodule : flash_write_guard_and_page_lock_tb
`default_nettype wire
